// ---- hw/pcc_pkg.sv ----
// Register map, field layout, reset values and types of the clock conditioner
package pcc_pkg;
	localparam int unsigned AW              = 8;
	localparam logic [7:0]  ADDR_CTRL       = 8'h00;
	localparam logic [7:0]  ADDR_DIV        = 8'h04;
	localparam logic [7:0]  ADDR_DLY        = 8'h08;
	localparam logic [7:0]  ADDR_STATUS     = 8'h0c;
	localparam logic [7:0]  ADDR_CLEAR      = 8'h10;
	localparam logic [7:0]  ADDR_IRQ_EN     = 8'h14;
	localparam logic [7:0]  ADDR_STATE      = 8'h18;
	localparam int unsigned CTRL_W          = 10;
	localparam int unsigned DIV_W           = 4;
	localparam int unsigned DIV_A_LSB       = 0;
	localparam int unsigned DIV_B_LSB       = 4;
	localparam int unsigned DIV_C_LSB       = 8;
	localparam int unsigned GDLY_W          = 4;
	localparam int unsigned CDLY_W          = 5;
	localparam int unsigned DLY_A_LSB       = 0;
	localparam int unsigned DLY_B_LSB       = 4;
	localparam int unsigned DLY_C_LSB       = 8;
	localparam int unsigned DLY_FB_LSB      = 12;
	localparam int unsigned DLY_YB_LSB      = 16;
	localparam int unsigned DLY_YC_LSB      = 21;
	localparam int unsigned EV_W            = 4;
	localparam logic [31:0] CTRL_RST        = 32'h0000_0020;
	localparam logic [31:0] DIV_RST         = 32'h0000_0444;
	localparam logic [31:0] DLY_RST         = 32'h0000_0000;
	localparam logic [31:0] IRQ_EN_RST      = 32'h0000_0000;
	localparam logic [2:0]  OA_SEL_BYPASS   = 3'h1;
	localparam int unsigned LOCK_COUNT      = 8;
	localparam int unsigned REF_TIMEOUT     = 255;

	typedef enum logic [1:0] {
		LK_SLEEP   = 2'b00,
		LK_ACQUIRE = 2'b01,
		LK_LOCKED  = 2'b10
	} pcc_lock_state_t;

	// Index 0 primary, 1 secondary 1, 2 secondary 2, 3 core 1, 4 core 2
	typedef struct packed {
		logic [4:0] en;
		logic       rc_osc;
		logic       ext_fb;
		logic [2:0] oa_sel;
	} pcc_ctrl_t;

	typedef struct packed {
		logic sync_ignored;
		logic sync_taken;
		logic lock_lost;
		logic lock_gained;
	} pcc_event_t;
endpackage : pcc_pkg

// ---- hw/pcc_clk_div.sv ----
// Output divider with resynchronising reset
`timescale 1ns/10ps
module pcc_clk_div #(
	parameter int unsigned W = 5
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         clear,
	input  wire logic         resync,
	input  wire logic         tick,
	input  wire logic [W-1:0] period,
	output logic              clk_out
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic [W-1:0] span;
	logic [W-1:0] high;

	// Zero period runs as one tick; high phase is the larger half, so odd periods give half steps
	assign span = (period == '0) ? W'(1) : period;
	assign high = (span >> 1) + W'(span[0]);

	always_comb begin
		cnt_nxt = cnt_r;
		if (resync) begin
			cnt_nxt = '0;
		end else if (tick) begin
			cnt_nxt = (cnt_r >= span - W'(1)) ? '0 : cnt_r + W'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r   <= '0;
			clk_out <= 1'b0;
		end else if (clear) begin
			cnt_r   <= '0;
			clk_out <= 1'b0;
		end else begin
			cnt_r   <= cnt_nxt;
			clk_out <= (cnt_nxt < high);
		end
	end
endmodule : pcc_clk_div

// ---- hw/pcc_delay_line.sv ----
// Tapped delay element for one clock path
`timescale 1ns/10ps
module pcc_delay_line #(
	parameter int unsigned DEPTH = 16,
	parameter int unsigned TW    = $clog2(DEPTH)
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          clear,
	input  wire logic          din,
	input  wire logic [TW-1:0] tap,
	output logic               dout
);
	logic [DEPTH-1:0] sr_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sr_r <= '0;
			dout <= 1'b0;
		end else if (clear) begin
			sr_r <= '0;
			dout <= 1'b0;
		end else begin
			sr_r <= {sr_r[DEPTH-2:0], din};
			dout <= (tap == '0) ? din : sr_r[tap - TW'(1)];
		end
	end
endmodule : pcc_delay_line

// ---- hw/pcc_top.sv ----
// Clock conditioner with divider, delay, lock and APB register logic
`timescale 1ns/10ps
module pcc_top #(
	parameter int unsigned DLY_DEPTH      = 16,
	parameter int unsigned CORE_DLY_DEPTH = 32,
	parameter int unsigned LOCK_COUNT     = pcc_pkg::LOCK_COUNT,
	parameter int unsigned REF_TIMEOUT    = pcc_pkg::REF_TIMEOUT
) (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [pcc_pkg::AW-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic                   ref_clk_in,
	input  wire logic                   external_feedback_in,
	input  wire logic                   pll_sleep_n,
	input  wire logic                   bypass_divider_sync,
	input  wire logic                   half_step_divide,
	output logic                        primary_global_clk,
	output logic                        secondary_global_clk_1,
	output logic                        secondary_global_clk_2,
	output logic                        core_clk_1,
	output logic                        core_clk_2,
	output logic                        lock,
	output logic                        irq
);
	logic [4:0]                pin_meta_r;
	logic [4:0]                pin_sync_r;
	logic [4:0]                pin_prev_r;
	logic [31:0]               ctrl_r;
	logic [31:0]               div_r;
	logic [31:0]               dly_r;
	logic [pcc_pkg::EV_W-1:0]  sts_r;
	logic [pcc_pkg::EV_W-1:0]  sts_nxt;
	logic [pcc_pkg::EV_W-1:0]  irq_en_r;
	pcc_pkg::pcc_ctrl_t        cfg;
	pcc_pkg::pcc_event_t       ev;
	pcc_pkg::pcc_lock_state_t  lk_state_r;
	pcc_pkg::pcc_lock_state_t  lk_state_nxt;
	logic                      ref_s;
	logic                      ref_rise;
	logic                      ref_fall;
	logic                      awake;
	logic                      sync_rise;
	logic                      bypass;
	logic                      half_ok;
	logic                      tick_a;
	logic                      rsync_a;
	logic [4:0]                period_a;
	logic [4:0]                period_b;
	logic [4:0]                period_c;
	logic                      div_a;
	logic                      div_b;
	logic                      div_c;
	logic [4:0]                en_eff;
	logic [4:0]                dly_src;
	logic [4:0]                dly_out;
	logic [4:0]                taps [5];
	logic                      int_fb;
	logic                      int_fb_prev_r;
	logic                      fb_rise;
	logic [1:0]                fb_cnt_r;
	logic [3:0]                good_cnt_r;
	logic [7:0]                gap_r;
	logic                      good;
	logic                      wr;
	logic [31:0]               rd_data;

	// Mapped register check, used by the error answer only
	function automatic logic reg_hit(input logic [pcc_pkg::AW-1:0] a);
		reg_hit = (a == pcc_pkg::ADDR_CTRL) || (a == pcc_pkg::ADDR_DIV) ||
			(a == pcc_pkg::ADDR_DLY) || (a == pcc_pkg::ADDR_STATUS) ||
			(a == pcc_pkg::ADDR_CLEAR) || (a == pcc_pkg::ADDR_IRQ_EN) ||
			(a == pcc_pkg::ADDR_STATE);
	endfunction : reg_hit

	// Pin synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta_r <= 5'h00;
			pin_sync_r <= 5'h00;
			pin_prev_r <= 5'h00;
		end else begin
			pin_meta_r <= {half_step_divide, bypass_divider_sync, external_feedback_in, pll_sleep_n, ref_clk_in};
			pin_sync_r <= pin_meta_r;
			pin_prev_r <= pin_sync_r;
		end
	end

	assign cfg       = pcc_pkg::pcc_ctrl_t'(ctrl_r[pcc_pkg::CTRL_W-1:0]);
	assign ref_s     = pin_sync_r[0];
	assign ref_rise  = ref_s & ~pin_prev_r[0];
	assign ref_fall  = ~ref_s & pin_prev_r[0];
	assign awake     = pin_sync_r[1];
	assign sync_rise = pin_sync_r[3] & ~pin_prev_r[3];
	assign bypass    = (cfg.oa_sel == pcc_pkg::OA_SEL_BYPASS);
	assign half_ok   = bypass & cfg.rc_osc & pin_sync_r[4];

	// Primary mux input: reference edges in bypass, core rate otherwise
	assign tick_a   = bypass ? (ref_rise | (half_ok & ref_fall)) : 1'b1;
	assign period_a = bypass ? (half_ok ? {div_r[pcc_pkg::DIV_A_LSB +: pcc_pkg::DIV_W], 1'b1}
		: {1'b0, div_r[pcc_pkg::DIV_A_LSB +: pcc_pkg::DIV_W]})
		: 5'({1'b0, div_r[pcc_pkg::DIV_A_LSB +: pcc_pkg::DIV_W]} + 5'h01);
	assign rsync_a  = bypass ? sync_rise : ref_rise;
	assign period_b = 5'({1'b0, div_r[pcc_pkg::DIV_B_LSB +: pcc_pkg::DIV_W]} + 5'h01);
	assign period_c = 5'({1'b0, div_r[pcc_pkg::DIV_C_LSB +: pcc_pkg::DIV_W]} + 5'h01);

	// Three independent dividers, one per global mux
	pcc_clk_div #(.W(5)) u_div_a (
		.clk     (pclk),
		.rst_n   (presetn),
		.clear   (~awake),
		.resync  (rsync_a),
		.tick    (tick_a),
		.period  (period_a),
		.clk_out (div_a)
	);
	pcc_clk_div #(.W(5)) u_div_b (
		.clk     (pclk),
		.rst_n   (presetn),
		.clear   (~awake),
		.resync  (ref_rise),
		.tick    (1'b1),
		.period  (period_b),
		.clk_out (div_b)
	);
	pcc_clk_div #(.W(5)) u_div_c (
		.clk     (pclk),
		.rst_n   (presetn),
		.clear   (~awake),
		.resync  (ref_rise),
		.tick    (1'b1),
		.period  (period_c),
		.clk_out (div_c)
	);

	// Core copies share the secondary sources but have deeper delays
	assign dly_src  = {div_c, div_b, div_c, div_b, div_a};
	assign taps[0]  = {1'b0, dly_r[pcc_pkg::DLY_A_LSB +: pcc_pkg::GDLY_W]};
	assign taps[1]  = {1'b0, dly_r[pcc_pkg::DLY_B_LSB +: pcc_pkg::GDLY_W]};
	assign taps[2]  = {1'b0, dly_r[pcc_pkg::DLY_C_LSB +: pcc_pkg::GDLY_W]};
	assign taps[3]  = dly_r[pcc_pkg::DLY_YB_LSB +: pcc_pkg::CDLY_W];
	assign taps[4]  = dly_r[pcc_pkg::DLY_YC_LSB +: pcc_pkg::CDLY_W];

	for (genvar i = 0; i < 5; i++) begin : g_dly
		localparam int unsigned D = (i < 3) ? DLY_DEPTH : CORE_DLY_DEPTH;
		pcc_delay_line #(.DEPTH(D)) u_dly (
			.clk   (pclk),
			.rst_n (presetn),
			.clear (~awake),
			.din   (dly_src[i]),
			.tap   (taps[i][$clog2(D)-1:0]),
			.dout  (dly_out[i])
		);
	end

	// Feedback delay: primary divider output delayed by the FB tap, feeding the internal phase check only
	pcc_delay_line #(.DEPTH(DLY_DEPTH)) u_fb_dly (
		.clk   (pclk),
		.rst_n (presetn),
		.clear (~awake),
		.din   (div_a),
		.tap   (dly_r[pcc_pkg::DLY_FB_LSB +: $clog2(DLY_DEPTH)]),
		.dout  (int_fb)
	);

	// Secondary 2 group only with secondary 1 group, any enable turns primary on
	assign en_eff[0] = |cfg.en;
	assign en_eff[1] = cfg.en[1];
	assign en_eff[3] = cfg.en[3];
	assign en_eff[2] = cfg.en[2] & (cfg.en[1] | cfg.en[3]);
	assign en_eff[4] = cfg.en[4] & (cfg.en[1] | cfg.en[3]);

	// Output clocks, forced low in power-down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			primary_global_clk     <= 1'b0;
			secondary_global_clk_1 <= 1'b0;
			secondary_global_clk_2 <= 1'b0;
			core_clk_1             <= 1'b0;
			core_clk_2             <= 1'b0;
		end else begin
			primary_global_clk     <= awake & en_eff[0] & dly_out[0];
			secondary_global_clk_1 <= awake & en_eff[1] & dly_out[1];
			secondary_global_clk_2 <= awake & en_eff[2] & dly_out[2];
			core_clk_1             <= awake & en_eff[3] & dly_out[3];
			core_clk_2             <= awake & en_eff[4] & dly_out[4];
		end
	end

	// Phase check source: external pin or internal path
	assign fb_rise = cfg.ext_fb ? (pin_sync_r[2] & ~pin_prev_r[2]) : (int_fb & ~int_fb_prev_r);
	assign good    = (fb_cnt_r == 2'h1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_fb_prev_r <= 1'b0;
			fb_cnt_r      <= 2'h0;
			gap_r         <= 8'h00;
		end else begin
			int_fb_prev_r <= int_fb;
			if (ref_rise || !awake) begin
				fb_cnt_r <= {1'b0, fb_rise && awake};   // Aligned edge opens the new period
				gap_r    <= 8'h00;
			end else begin
				if (fb_rise && fb_cnt_r != 2'h3) begin
					fb_cnt_r <= fb_cnt_r + 2'h1;
				end
				if (gap_r != 8'(REF_TIMEOUT)) begin
					gap_r <= gap_r + 8'h01;
				end
			end
		end
	end

	// Lock state machine
	always_comb begin
		lk_state_nxt = lk_state_r;
		unique case (lk_state_r)
			pcc_pkg::LK_SLEEP: begin
				lk_state_nxt = pcc_pkg::LK_ACQUIRE;
			end
			pcc_pkg::LK_ACQUIRE: begin
				if (ref_rise && good && good_cnt_r == 4'(LOCK_COUNT - 1)) begin
					lk_state_nxt = pcc_pkg::LK_LOCKED;
				end
			end
			pcc_pkg::LK_LOCKED: begin
				if ((ref_rise && !good) || gap_r == 8'(REF_TIMEOUT)) begin
					lk_state_nxt = pcc_pkg::LK_ACQUIRE;
				end
			end
			default: begin
				lk_state_nxt = pcc_pkg::LK_SLEEP;
			end
		endcase
		if (!awake) begin
			lk_state_nxt = pcc_pkg::LK_SLEEP;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lk_state_r <= pcc_pkg::LK_SLEEP;
			good_cnt_r <= 4'h0;
			lock       <= 1'b0;
		end else begin
			lk_state_r <= lk_state_nxt;
			lock       <= (lk_state_r == pcc_pkg::LK_LOCKED) && awake;
			if (!awake || (ref_rise && !good) || lk_state_r != pcc_pkg::LK_ACQUIRE) begin
				good_cnt_r <= 4'h0;
			end else if (ref_rise) begin
				good_cnt_r <= good_cnt_r + 4'h1;
			end
		end
	end

	// Events
	assign ev.lock_gained  = (lk_state_r != pcc_pkg::LK_LOCKED) && (lk_state_nxt == pcc_pkg::LK_LOCKED);
	assign ev.lock_lost    = (lk_state_r == pcc_pkg::LK_LOCKED) && (lk_state_nxt != pcc_pkg::LK_LOCKED);
	assign ev.sync_taken   = sync_rise & bypass & awake;
	assign ev.sync_ignored = sync_rise & ~bypass;

	// APB slave, answer in the first access cycle
	assign wr      = psel & penable & pready & pwrite;
	assign sts_nxt = (sts_r & ~((wr && paddr == pcc_pkg::ADDR_CLEAR) ? pwdata[pcc_pkg::EV_W-1:0] : 4'h0))
		| pcc_pkg::EV_W'(ev);

	always_comb begin
		rd_data = 32'h0000_0000;
		unique case (paddr)
			pcc_pkg::ADDR_CTRL:   rd_data = ctrl_r;
			pcc_pkg::ADDR_DIV:    rd_data = div_r;
			pcc_pkg::ADDR_DLY:    rd_data = dly_r;
			pcc_pkg::ADDR_STATUS: rd_data = {28'h0, sts_r};
			pcc_pkg::ADDR_IRQ_EN: rd_data = {28'h0, irq_en_r};
			pcc_pkg::ADDR_STATE:  rd_data = {24'h0, en_eff, bypass, awake, lock};
			default:              rd_data = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~reg_hit(paddr);
			prdata  <= (psel && !penable && !pwrite) ? rd_data : 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r   <= pcc_pkg::CTRL_RST;
			div_r    <= pcc_pkg::DIV_RST;
			dly_r    <= pcc_pkg::DLY_RST;
			irq_en_r <= pcc_pkg::IRQ_EN_RST[pcc_pkg::EV_W-1:0];
		end else if (wr) begin
			if (paddr == pcc_pkg::ADDR_CTRL) ctrl_r <= {22'h0, pwdata[pcc_pkg::CTRL_W-1:0]};
			if (paddr == pcc_pkg::ADDR_DIV) div_r <= {20'h0, pwdata[11:0]};
			if (paddr == pcc_pkg::ADDR_DLY) dly_r <= {6'h0, pwdata[25:0]};
			if (paddr == pcc_pkg::ADDR_IRQ_EN) irq_en_r <= pwdata[pcc_pkg::EV_W-1:0];
		end
	end

	// Sticky status, set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sts_r <= 4'h0;
			irq   <= 1'b0;
		end else begin
			sts_r <= sts_nxt;
			irq   <= |(sts_nxt & irq_en_r);
		end
	end

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_sleep_low;
		!awake |=> !(primary_global_clk || secondary_global_clk_1 || secondary_global_clk_2 || core_clk_1 || core_clk_2);
	endproperty
	a_sleep_low: assert property (p_sleep_low) else $error("output clock active in power-down");

	property p_lock_sleep;
		!awake ##1 !awake |-> !lock;
	endproperty
	a_lock_sleep: assert property (p_lock_sleep) else $error("lock high in power-down");

	property p_lock_cause;
		$rose(lock) |-> $past(ref_rise, 2) && $past(good, 2);
	endproperty
	a_lock_cause: assert property (p_lock_cause) else $error("lock rose without good reference edge");

	property p_enable_legal;
		(|en_eff[4:1] |-> en_eff[0]) and (|{en_eff[4], en_eff[2]} |-> |{en_eff[3], en_eff[1]});
	endproperty
	a_enable_legal: assert property (p_enable_legal) else $error("illegal output grouping");

	property p_bypass_sync;
		bypass && sync_rise && awake |=> div_a && (u_div_a.cnt_r == 5'h00);
	endproperty
	a_bypass_sync: assert property (p_bypass_sync) else $error("bypass sync did not reset divider");

	property p_core_sync;
		!bypass && ref_rise && awake |=> div_a && (u_div_a.cnt_r == 5'h00);
	endproperty
	a_core_sync: assert property (p_core_sync) else $error("internal sync reset missing");

	property p_bypass_ticks;
		bypass && !half_ok && awake ##1 $changed(u_div_a.cnt_r) |-> $past(ref_rise || sync_rise);
	endproperty
	a_bypass_ticks: assert property (p_bypass_ticks) else $error("bypass divider moved without edge");

	property p_ext_fb;
		cfg.ext_fb && awake && !ref_rise && !(pin_sync_r[2] && !pin_prev_r[2]) |=> $stable(fb_cnt_r);
	endproperty
	a_ext_fb: assert property (p_ext_fb) else $error("feedback count moved without external edge");

	c_lock:      cover property ($rose(lock));
	c_sync:      cover property (ev.sync_taken);
	c_half_step: cover property (half_ok && ref_fall);
	c_irq:       cover property ($rose(irq));
endmodule : pcc_top

// ---- tb/pcc_fabric_model.sv ----
// Fabric-side model supplying the reference clock and the feedback pad
`timescale 1ns/10ps
module pcc_fabric_model #(
	parameter int unsigned HALF = 5
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic run,
	input  wire logic fb_good,
	output logic      ref_clk_in,
	output logic      external_feedback_in
);
	int unsigned cnt;

	// Reference toggles every HALF cycles, holds its level when stopped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt        <= 0;
			ref_clk_in <= 1'b0;
		end else if (run) begin
			if (cnt == HALF - 1) begin
				cnt        <= 0;
				ref_clk_in <= ~ref_clk_in;
			end else begin
				cnt <= cnt + 1;
			end
		end
	end

	// Dedicated feedback pad follows the reference, stuck low when broken
	assign external_feedback_in = fb_good & ref_clk_in;
endmodule : pcc_fabric_model

// ---- tb/tb_pll_clock_conditioner.sv ----
// Self-checking bench for the clock conditioner
`timescale 1ns/10ps
module tb_pll_clock_conditioner;
	logic               pclk, presetn, psel, penable, pwrite;
	logic [7:0]         paddr;
	logic [31:0]        pwdata, prdata;
	logic               pready, pslverr, ref_clk_in, external_feedback_in, pll_sleep_n;
	logic               bypass_divider_sync, half_step_divide, lock, irq, run, fb_good;
	logic [4:0]         outs;
	int                 num_errors, check_count;
	pcc_pkg::pcc_ctrl_t ctrl;
	logic [7:0]         ra [6] = '{pcc_pkg::ADDR_CTRL, pcc_pkg::ADDR_DIV, pcc_pkg::ADDR_DLY,
		pcc_pkg::ADDR_IRQ_EN, pcc_pkg::ADDR_CLEAR, 8'h1c};
	logic [31:0]        rv [6] = '{pcc_pkg::CTRL_RST, pcc_pkg::DIV_RST, pcc_pkg::DLY_RST,
		pcc_pkg::IRQ_EN_RST, 32'h0, 32'h0};
	logic [4:0]         en_in [6] = '{5'h01, 5'h04, 5'h02, 5'h08, 5'h12, 5'h1f};
	logic [4:0]         en_ex [6] = '{5'h01, 5'h01, 5'h03, 5'h09, 5'h13, 5'h1f};

	pcc_top #(.LOCK_COUNT(2), .REF_TIMEOUT(20)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ref_clk_in(ref_clk_in),
		.external_feedback_in(external_feedback_in), .pll_sleep_n(pll_sleep_n),
		.bypass_divider_sync(bypass_divider_sync), .half_step_divide(half_step_divide),
		.primary_global_clk(outs[0]), .secondary_global_clk_1(outs[1]), .secondary_global_clk_2(outs[2]),
		.core_clk_1(outs[3]), .core_clk_2(outs[4]), .lock(lock), .irq(irq));

	pcc_fabric_model #(.HALF(5)) far (.pclk(pclk), .presetn(presetn), .run(run), .fb_good(fb_good),
		.ref_clk_in(ref_clk_in), .external_feedback_in(external_feedback_in));

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		tally_and_finish();
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			num_errors++;
			$display("[ERR] pready expected 1 seen %b", pready);
		end
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(a, 1'b1, d, q, e);
	endtask : wr

	task automatic rd(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		logic [31:0] q;
		logic        e;
		apb(a, 1'b0, 32'h0, q, e);
		chk(name, exp, q & m);
	endtask : rd

	task automatic scan(input int n, output logic [4:0] hi, output logic [4:0] tg);
		logic [4:0] p;
		@(negedge pclk);
		p = outs;
		hi = outs;
		tg = 5'h0;
		repeat (n) begin
			@(negedge pclk);
			hi |= outs;
			tg |= outs ^ p;
			p = outs;
		end
		@(posedge pclk);
	endtask : scan

	// Cycles from the second rise of output a to the next rise of output b
	task automatic edge_gap(input int a, input int b, output int p);
		logic [4:0] q;
		int         n;
		int         r;
		q = 5'h1f;
		n = 0;
		r = 0;
		p = 0;
		while (r < 3 && n < 400) begin
			@(negedge pclk);
			n++;
			if (r == 2) p++;
			if (r < 2 && outs[a] === 1'b1 && q[a] === 1'b0) r++;
			else if (r == 2 && outs[b] === 1'b1 && q[b] === 1'b0) r++;
			q = outs;
		end
		@(posedge pclk);
	endtask : edge_gap

	task automatic wait_lock(input logic want);
		int n;
		n = 0;
		while (lock !== want && n < 300) begin
			@(negedge pclk);
			n++;
		end
		chk("lock", {31'h0, want}, {31'h0, lock});
		@(posedge pclk);
	endtask : wait_lock

	task automatic irq_is(input logic exp);
		repeat (2) @(negedge pclk);
		chk("irq", {31'h0, exp}, {31'h0, irq});
		@(posedge pclk);
	endtask : irq_is

	task automatic set_ctrl(input logic [4:0] en, input logic ext, input logic [2:0] oa);
		ctrl = '{en: en, rc_osc: 1'b0, ext_fb: ext, oa_sel: oa};
		wr(pcc_pkg::ADDR_CTRL, {22'h0, ctrl});
	endtask : set_ctrl

	task automatic pulse_sync(input logic [3:0] exp);
		wr(pcc_pkg::ADDR_CLEAR, 32'hf);
		repeat (12) @(posedge pclk);
		bypass_divider_sync <= 1'b1;
		repeat (8) @(posedge pclk);
		bypass_divider_sync <= 1'b0;
		rd("sync status", pcc_pkg::ADDR_STATUS, 32'hc, {28'h0, exp});
	endtask : pulse_sync

	initial begin
		logic [31:0] q;
		logic        e;
		logic [4:0]  hi, tg;
		int          p;
		num_errors = 0;
		check_count = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pll_sleep_n = 1'b0;
		bypass_divider_sync = 1'b0;
		half_step_divide = 1'b0;
		run = 1'b1;
		fb_good = 1'b1;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		scan(30, hi, tg);
		chk("outputs asleep", 32'h0, {27'h0, hi});
		chk("lock asleep", 32'h0, {31'h0, lock});
		for (int i = 0; i < 6; i++) begin
			apb(ra[i], 1'b0, 32'h0, q, e);
			chk("reset value", rv[i], q);
			chk("slave error", {31'h0, i == 5}, {31'h0, e});
		end
		wr(pcc_pkg::ADDR_DIV, 32'h0000_0449);
		wr(pcc_pkg::ADDR_IRQ_EN, 32'h1);
		pll_sleep_n <= 1'b1;
		wait_lock(1'b1);
		rd("lock gained", pcc_pkg::ADDR_STATUS, 32'h1, 32'h1);
		irq_is(1'b1);
		wr(pcc_pkg::ADDR_IRQ_EN, 32'h0);
		irq_is(1'b0);
		wr(pcc_pkg::ADDR_IRQ_EN, 32'h1);
		irq_is(1'b1);
		wr(pcc_pkg::ADDR_CLEAR, 32'h1);
		irq_is(1'b0);
		for (int i = 0; i < 6; i++) begin
			set_ctrl(en_in[i], 1'b0, 3'h0);
			rd("effective enables", pcc_pkg::ADDR_STATE, 32'hf8, {24'h0, en_ex[i], 3'h0});
			scan(40, hi, tg);
			chk("running outputs", {27'h0, en_ex[i]}, {27'h0, tg});
		end
		wr(pcc_pkg::ADDR_DLY, 32'h0003_0200);
		edge_gap(1, 3, p);
		chk("core copy delay", 32'h3, p);
		edge_gap(1, 2, p);
		chk("secondary delay", 32'h2, p);
		wr(pcc_pkg::ADDR_DLY, 32'h0);
		fb_good <= 1'b0;
		repeat (60) @(posedge pclk);
		chk("internal loop lock", 32'h1, {31'h0, lock});
		set_ctrl(5'h1f, 1'b1, 3'h0);
		wait_lock(1'b0);
		fb_good <= 1'b1;
		wait_lock(1'b1);
		set_ctrl(5'h1f, 1'b0, 3'h0);
		pulse_sync(4'h8);
		set_ctrl(5'h1f, 1'b0, pcc_pkg::OA_SEL_BYPASS);
		pulse_sync(4'h4);
		half_step_divide <= 1'b1;
		wr(pcc_pkg::ADDR_DIV, 32'h0000_0442);
		edge_gap(0, 0, p);
		chk("bypass period", 32'h14, p);
		ctrl = '{en: 5'h1f, rc_osc: 1'b1, ext_fb: 1'b0, oa_sel: pcc_pkg::OA_SEL_BYPASS};
		wr(pcc_pkg::ADDR_CTRL, {22'h0, ctrl});
		edge_gap(0, 0, p);
		chk("half step period", 32'h19, p);
		half_step_divide <= 1'b0;
		wr(pcc_pkg::ADDR_DIV, 32'h0000_0449);
		set_ctrl(5'h1f, 1'b0, 3'h0);
		run <= 1'b0;
		wait_lock(1'b0);
		scan(20, hi, tg);
		chk("free running", 32'h1, {31'h0, tg[0]});
		run <= 1'b1;
		pll_sleep_n <= 1'b0;
		repeat (6) @(posedge pclk);
		scan(30, hi, tg);
		chk("outputs asleep", 32'h0, {27'h0, hi});
		chk("lock asleep", 32'h0, {31'h0, lock});
		pll_sleep_n <= 1'b1;
		wait_lock(1'b1);
		tally_and_finish();
	end
endmodule : tb_pll_clock_conditioner
